// ---- design/sec_bus_arbiter.sv ----
// Secondary bus arbiter with parking, preemption and primary parking
`timescale 1ns/1ps
module sec_bus_arbiter
  import sec_arb_pkg::*;
(
  // Clock and reset
  input  wire logic               ref_clk_in,
  input  wire logic               reset_n_in,
  // AXI4-Lite register port
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic      [1:0]         s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic      [31:0]        s_axi_rdata,
  output logic      [1:0]         s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Secondary bus pins
  input  wire logic [NUM_EXT-1:0] sec_req_n_in,
  output logic      [NUM_EXT-1:0] sec_gnt_n_out,
  input  wire logic               sec_frame_n_in,
  input  wire logic               downstream_initiator_ready_n_in,
  input  wire logic               sec_ext_gnt_n_in,
  output logic                    sec_ext_req_n_out,
  output logic                    sec_ad_oe_out,
  output logic                    sec_par_oe_out,
  // Bridge secondary initiator
  input  wire logic               bridge_sec_req_in,
  output logic                    bridge_sec_gnt_out,
  // Primary bus pins
  input  wire logic               pri_gnt_n_in,
  output logic                    pri_req_n_out,
  input  wire logic               pri_frame_n_in,
  input  wire logic               pri_irdy_n_in,
  output logic                    pri_frame_n_out,
  output logic                    pri_frame_oe_out,
  output logic                    pri_ad_oe_out,
  output logic                    upstream_parity_oe_out,
  // Bridge primary initiator
  input  wire logic               up_pending_in,
  input  wire logic               pri_term_in,
  output logic                    pri_start_out
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic [NUM_EXT-1:0] onehot(input logic [2:0] idx);
    onehot = NUM_EXT'(1) << idx;
  endfunction

  function automatic logic [6:0] preempt_delay(input logic [2:0] code);
    preempt_delay = (code == 3'h0) ? 7'h00 : 7'h01 << (code - 3'h1);
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [NUM_EXT-1:0] sreq_n_s;
  logic               sframe_n_s;
  logic               sirdy_n_s;
  logic               sext_gnt_n_s;
  logic               pgnt_n_s;
  logic               pframe_n_s;
  logic               pirdy_n_s;

  pin_sync #(.W(NUM_EXT + 6), .RST('1)) u_sync (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({sec_req_n_in, sec_frame_n_in, downstream_initiator_ready_n_in, sec_ext_gnt_n_in,
                  pri_gnt_n_in, pri_frame_n_in, pri_irdy_n_in}),
    .sync_out   ({sreq_n_s, sframe_n_s, sirdy_n_s, sext_gnt_n_s, pgnt_n_s, pframe_n_s, pirdy_n_s})
  );

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic       arb_off;
  logic       park_brg;
  logic       pre_off;
  logic [2:0] pre_code;
  logic [4:0] hi_level;
  logic [2:0] owner;
  logic       active;

  logic [7:0] aw_addr;
  logic       aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       w_held;
  logic       do_write;

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[7:2] == OFS_CTRL[7:2] || aw_addr[7:2] == OFS_PREEMPT[7:2] ||
                         aw_addr[7:2] == OFS_STATUS[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      arb_off  <= RST_ARB_OFF;
      park_brg <= RST_PARK_BRG;
      pre_off  <= RST_PRE_OFF;
      pre_code <= RST_PRE_CODE;
      hi_level <= RST_LEVEL;
    end else if (do_write) begin
      if (aw_addr[7:2] == OFS_CTRL[7:2] && w_strb[0]) begin
        arb_off  <= w_data[CTRL_ARB_OFF];
        park_brg <= w_data[CTRL_PARK_BRG];
      end
      if (aw_addr[7:2] == OFS_PREEMPT[7:2]) begin
        if (w_strb[3]) begin
          pre_off  <= w_data[PRE_OFF_BIT];
          pre_code <= w_data[PRE_CODE_LSB +: 3];
        end
        if (w_strb[0]) begin
          hi_level <= w_data[PRE_LEVEL_LSB +: NUM_REQ];
        end
      end
    end
  end

  // Read channel, one word per request
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        unique case (s_axi_araddr[7:2])
          OFS_CTRL[7:2]: begin
            s_axi_rdata[CTRL_ARB_OFF]  <= arb_off;
            s_axi_rdata[CTRL_PARK_BRG] <= park_brg;
          end
          OFS_PREEMPT[7:2]: begin
            s_axi_rdata[PRE_OFF_BIT]                <= pre_off;
            s_axi_rdata[PRE_CODE_LSB +: 3]          <= pre_code;
            s_axi_rdata[PRE_LEVEL_LSB +: NUM_REQ]   <= hi_level;
          end
          OFS_STATUS[7:2]: begin
            s_axi_rdata[ST_OWNER_LSB +: 3]          <= owner;
            s_axi_rdata[ST_ACTIVE_BIT]              <= active;
            s_axi_rdata[ST_REQ_LSB +: NUM_REQ]      <= {bridge_sec_req_in, ~sreq_n_s};
          end
          default: s_axi_rresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Secondary arbitration
  // ------------------------------------------------------------
  logic [NUM_REQ-1:0] req_vec;
  logic [2:0]         last_hi;
  logic [2:0]         last_lo;
  logic               hi_valid;
  logic [2:0]         hi_idx;
  logic               lo_valid;
  logic [2:0]         lo_idx;
  logic               win_valid;
  logic [2:0]         win;
  logic               bus_busy;
  logic               owner_req;
  logic               others_wait;
  logic [4:0]         to_cnt;
  logic               to_inc;
  logic               to_hit;
  logic [6:0]         pre_cnt;
  logic               pre_hit;
  logic               release_gnt;
  logic [2:0]         next_owner;
  logic               next_active;
  logic               new_grant;

  assign req_vec     = {bridge_sec_req_in, ~sreq_n_s};
  assign bus_busy    = !sframe_n_s || !sirdy_n_s;
  assign win_valid   = hi_valid || lo_valid;
  assign win         = hi_valid ? hi_idx : lo_idx;
  assign owner_req   = req_vec[owner];
  assign others_wait = win_valid && (win != owner);
  assign to_inc      = active && !bus_busy && owner_req;
  assign to_hit      = to_inc && (to_cnt == IDLE_TIMEOUT - 5'h01);
  assign pre_hit     = !pre_off && active && owner_req && others_wait &&
                       (pre_cnt >= preempt_delay(pre_code));
  assign release_gnt = active && ((others_wait && !owner_req) || pre_hit || to_hit ||
                                  (park_brg && !win_valid && owner != BRIDGE_IDX));
  assign new_grant   = next_active && (!active || next_owner != owner);

  rr_pick u_pick_hi (
    .req_in    (req_vec & hi_level),
    .last_in   (last_hi),
    .valid_out (hi_valid),
    .idx_out   (hi_idx)
  );

  rr_pick u_pick_lo (
    .req_in    (req_vec & ~hi_level),
    .last_in   (last_lo),
    .valid_out (lo_valid),
    .idx_out   (lo_idx)
  );

  always_comb begin
    next_owner  = owner;
    next_active = active;
    if (arb_off) begin
      next_active = 1'b0;
    end else if (!active) begin
      next_active = 1'b1;
      next_owner  = win_valid ? win : (park_brg ? BRIDGE_IDX : owner);
    end else if (release_gnt) begin
      if (bus_busy && others_wait) begin
        next_owner = win;
      end else begin
        next_active = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      owner         <= BRIDGE_IDX;
      active        <= 1'b1;
      sec_gnt_n_out <= '1;
    end else begin
      owner         <= next_owner;
      active        <= next_active;
      sec_gnt_n_out <= ~(onehot(next_owner) & {NUM_EXT{next_active}});
    end
  end

  // Rotation pointers per level
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      last_hi <= BRIDGE_IDX;
      last_lo <= BRIDGE_IDX;
    end else if (new_grant && win_valid) begin
      if (hi_level[next_owner]) begin
        last_hi <= next_owner;
      end else begin
        last_lo <= next_owner;
      end
    end
  end

  // Idle-grant and preemption counters
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      to_cnt  <= 5'h00;
      pre_cnt <= 7'h00;
    end else begin
      to_cnt  <= (to_inc && !to_hit && !new_grant) ? to_cnt + 5'h01 : 5'h00;
      if (!others_wait || new_grant) begin
        pre_cnt <= 7'h00;
      end else if (pre_cnt != PREEMPT_MAX) begin
        pre_cnt <= pre_cnt + 7'h01;
      end
    end
  end

  // Bridge grant and its secondary parking
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      bridge_sec_gnt_out <= 1'b0;
      sec_ext_req_n_out  <= 1'b1;
      sec_ad_oe_out      <= 1'b0;
      sec_par_oe_out     <= 1'b0;
    end else begin
      bridge_sec_gnt_out <= arb_off ? !sext_gnt_n_s : (next_active && next_owner == BRIDGE_IDX);
      sec_ext_req_n_out  <= !(arb_off && bridge_sec_req_in);
      sec_ad_oe_out      <= bridge_sec_gnt_out && !bridge_sec_req_in && !bus_busy;
      sec_par_oe_out     <= sec_ad_oe_out && bridge_sec_gnt_out && !bridge_sec_req_in && !bus_busy;
    end
  end

  // ------------------------------------------------------------
  // Primary request, parking and start
  // ------------------------------------------------------------
  logic [1:0] backoff;
  logic       pri_idle;
  logic       pri_start;

  assign pri_idle  = pframe_n_s && pirdy_n_s;
  assign pri_start = up_pending_in && backoff == 2'h0 && !pri_term_in && !pgnt_n_s && pri_idle &&
                     !pri_frame_oe_out && (pri_ad_oe_out || !pri_req_n_out);

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      backoff       <= 2'h0;
      pri_req_n_out <= 1'b1;
    end else begin
      if (pri_term_in) begin
        backoff <= REQ_BACKOFF - 2'h1;
      end else if (backoff != 2'h0) begin
        backoff <= backoff - 2'h1;
      end
      pri_req_n_out <= !(up_pending_in && !pri_term_in && backoff == 2'h0);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      pri_ad_oe_out          <= 1'b0;
      upstream_parity_oe_out <= 1'b0;
      pri_frame_n_out        <= 1'b1;
      pri_frame_oe_out       <= 1'b0;
      pri_start_out          <= 1'b0;
    end else begin
      pri_ad_oe_out          <= !pgnt_n_s && pri_req_n_out && pri_idle;
      upstream_parity_oe_out <= pri_ad_oe_out && !pgnt_n_s;
      pri_frame_n_out        <= !pri_start;
      pri_frame_oe_out       <= pri_start;
      pri_start_out          <= pri_start;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_term;
    pri_term_in;
  endsequence
  sequence s_req_off_two;
    pri_req_n_out [*2];
  endsequence

  property p_backoff;
    s_term |=> s_req_off_two;
  endproperty
  a_backoff: assert property (p_backoff) else $error("primary request not dropped");

  property p_idle_gap;
    ($past(!bus_busy) && |(~sec_gnt_n_out & $past(sec_gnt_n_out))) |-> !(|(sec_gnt_n_out & ~$past(sec_gnt_n_out)));
  endproperty
  a_idle_gap: assert property (p_idle_gap) else $error("grant overlap on idle bus");

  property p_timeout;
    (to_cnt == 5'h0f && to_inc && !arb_off) |=> !active;
  endproperty
  a_timeout: assert property (p_timeout) else $error("idle grant not withdrawn");

  property p_preempt;
    (pre_hit && !arb_off && !bus_busy) |=> (!active ##1 active);
  endproperty
  a_preempt: assert property (p_preempt) else $error("preemption failed");

  property p_reset_park;
    $rose(reset_n_in) |-> (active && owner == BRIDGE_IDX && !pre_off && pre_code == 3'h0 && !park_brg);
  endproperty
  a_reset_park: assert property (@(posedge ref_clk_in) p_reset_park) else $error("bad reset state");

  property p_park_last;
    (active && !win_valid && !park_brg && !arb_off && !to_hit) |=> $stable(owner) && active;
  endproperty
  a_park_last: assert property (p_park_last) else $error("parked grant moved");

  property p_ext_disable;
    arb_off |=> (sec_gnt_n_out == '1);
  endproperty
  a_ext_disable: assert property (p_ext_disable) else $error("grant while arbiter off");

  property upstream_parity_late;
    $rose(upstream_parity_oe_out) |-> $past(pri_ad_oe_out);
  endproperty
  a_par_late: assert property (upstream_parity_late) else $error("parity driven before address");

  property p_float;
    $past(pgnt_n_s) |-> !pri_ad_oe_out && !upstream_parity_oe_out;
  endproperty
  a_float: assert property (p_float) else $error("primary not released");

  property p_pri_park;
    pri_ad_oe_out |-> $past(!pgnt_n_s && pri_req_n_out && pri_idle);
  endproperty
  a_pri_park: assert property (p_pri_park) else $error("primary parked wrongly");

endmodule

// ---- design/sec_arb_pkg.sv ----
// Shared constants for the secondary bus arbiter and parking logic
package sec_arb_pkg;

  // ------------------------------------------------------------
  // Requesters
  // ------------------------------------------------------------
  localparam int          NUM_EXT        = 4;
  localparam int          NUM_REQ        = 5;
  localparam logic [2:0]  BRIDGE_IDX     = 3'h4;

  // ------------------------------------------------------------
  // Arbitration timing in secondary clocks
  // ------------------------------------------------------------
  localparam logic [4:0]  IDLE_TIMEOUT   = 5'h10;
  localparam logic [6:0]  PREEMPT_MAX    = 7'h40;
  localparam logic [1:0]  REQ_BACKOFF    = 2'h2;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL       = 8'h48;
  localparam logic [7:0]  OFS_PREEMPT    = 8'h4c;
  localparam logic [7:0]  OFS_STATUS     = 8'h50;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int          CTRL_ARB_OFF   = 0;
  localparam int          CTRL_PARK_BRG  = 1;
  localparam int          PRE_OFF_BIT    = 31;
  localparam int          PRE_CODE_LSB   = 28;
  localparam int          PRE_LEVEL_LSB  = 0;
  localparam int          ST_OWNER_LSB   = 0;
  localparam int          ST_ACTIVE_BIT  = 3;
  localparam int          ST_REQ_LSB     = 8;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic        RST_PRE_OFF    = 1'b0;
  localparam logic [2:0]  RST_PRE_CODE   = 3'h0;
  localparam logic [4:0]  RST_LEVEL      = 5'h00;
  localparam logic        RST_PARK_BRG   = 1'b0;
  localparam logic        RST_ARB_OFF    = 1'b0;

  // ------------------------------------------------------------
  // AXI responses
  // ------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage

// ---- design/pin_sync.sv ----
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '1
) (
  // Clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         reset_n_in,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      stage1   <= RST;
      sync_out <= RST;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ---- design/rr_pick.sv ----
// Round-robin picker over the five requesters of one level
`timescale 1ns/1ps
module rr_pick
  import sec_arb_pkg::*;
(
  // Requests and last winner
  input  wire logic [NUM_REQ-1:0] req_in,
  input  wire logic [2:0]         last_in,
  // Result
  output logic                    valid_out,
  output logic      [2:0]         idx_out
);

  always_comb begin
    logic [2:0] cand;
    cand      = last_in;
    valid_out = 1'b0;
    idx_out   = last_in;
    for (int k = 0; k < NUM_REQ; k++) begin
      cand = (cand == BRIDGE_IDX) ? 3'h0 : cand + 3'h1;
      if (!valid_out && req_in[cand]) begin
        valid_out = 1'b1;
        idx_out   = cand;
      end
    end
  end

endmodule

// ---- tb/master_model.sv ----
// Behavioural external secondary bus masters
`timescale 1ns/1ps
module master_model
  import sec_arb_pkg::*;
(
  input  wire logic               ref_clk_in,
  input  wire logic               reset_n_in,
  input  wire logic [NUM_EXT-1:0] want_in,
  input  wire logic [NUM_EXT-1:0] lazy_in,
  input  wire logic [NUM_EXT-1:0] gnt_n_in,
  output logic      [NUM_EXT-1:0] req_n_out,
  output logic                    frame_n_out,
  output logic                    irdy_n_out
);
  logic [1:0] left;
  assign req_n_out = ~want_in;
  assign irdy_n_out = frame_n_out;
  // Lazy masters never start, so the idle timeout can bite
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      frame_n_out <= 1'b1;
      left <= 2'h0;
    end else if (left != 2'h0) begin
      left <= left - 2'h1;
      frame_n_out <= (left == 2'h1);
    end else if (|(~gnt_n_in & want_in & ~lazy_in) && frame_n_out) begin
      frame_n_out <= 1'b0;
      left <= 2'h2;
    end
  end
endmodule

// ---- tb/secondary_bus_arbiter_parking_test.sv ----
// Testbench for the secondary bus arbiter and parking logic
`timescale 1ns/1ps
module secondary_bus_arbiter_parking_test
  import sec_arb_pkg::*;
;
  logic ref_clk_in, reset_n_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [NUM_EXT-1:0] sec_req_n_in, sec_gnt_n_out, want, lazy;
  logic sec_frame_n_in, downstream_initiator_ready_n_in, sec_ext_gnt_n_in, sec_ext_req_n_out;
  logic sec_ad_oe_out, sec_par_oe_out, bridge_sec_req_in, bridge_sec_gnt_out, pri_gnt_n_in, pri_req_n_out;
  logic pri_frame_n_in, pri_irdy_n_in, pri_frame_n_out, pri_frame_oe_out, pri_ad_oe_out;
  logic upstream_parity_oe_out, up_pending_in, pri_term_in, pri_start_out;
  logic [4:0] gp;
  logic [3:0] idle_h;
  int failures, checks;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_s;
  row_s rows[4];
  sec_bus_arbiter u_sec_bus_arbiter (.ref_clk_in, .reset_n_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sec_req_n_in, .sec_gnt_n_out, .sec_frame_n_in, .downstream_initiator_ready_n_in, .sec_ext_gnt_n_in,
    .sec_ext_req_n_out, .sec_ad_oe_out, .sec_par_oe_out, .bridge_sec_req_in, .bridge_sec_gnt_out,
    .pri_gnt_n_in, .pri_req_n_out, .pri_frame_n_in, .pri_irdy_n_in, .pri_frame_n_out, .pri_frame_oe_out,
    .pri_ad_oe_out, .upstream_parity_oe_out, .up_pending_in, .pri_term_in, .pri_start_out);
  master_model u_master_model (.ref_clk_in, .reset_n_in, .want_in(want), .lazy_in(lazy),
    .gnt_n_in(sec_gnt_n_out), .req_n_out(sec_req_n_in), .frame_n_out(sec_frame_n_in),
    .irdy_n_out(downstream_initiator_ready_n_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic probe(input int s);
    case (s)
      0, 1, 2, 3: return sec_gnt_n_out[s];
      4: return bridge_sec_gnt_out;
      5: return sec_ad_oe_out;
      6: return pri_ad_oe_out;
      default: return pri_start_out;
    endcase
  endfunction
  task automatic wfor(input string nm, input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (probe(s) !== v && n < lim) begin
      @(posedge ref_clk_in);
      n++;
    end
    chk(nm, v, probe(s));
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk_in); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", RESP_OKAY, s_axi_bresp);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk_in); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk_in); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", d, s_axi_rdata);
    chk("rresp", r, s_axi_rresp);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Grant swap on an idle bus, or two external grants at once
  always @(posedge ref_clk_in) begin
    gp <= {bridge_sec_gnt_out, ~sec_gnt_n_out};
    idle_h <= reset_n_in ? {idle_h[2:0], sec_frame_n_in & downstream_initiator_ready_n_in} : 4'h0;
    if (reset_n_in && &idle_h && |(gp & ~{bridge_sec_gnt_out, ~sec_gnt_n_out})
        && |(~gp & {bridge_sec_gnt_out, ~sec_gnt_n_out})) begin
      failures++;
      $display("ERROR grant_swap expected gap seen same-cycle swap");
    end
    if (reset_n_in && $countones(~sec_gnt_n_out) > 1) begin
      failures++;
      $display("ERROR grant_count expected 1 seen %0d", $countones(~sec_gnt_n_out));
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    failures++;
    final_report;
  end
  initial begin
    failures = 0;
    checks = 0;
    {reset_n_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, want, lazy} = '0;
    {sec_ext_gnt_n_in, bridge_sec_req_in, pri_gnt_n_in, pri_frame_n_in, pri_irdy_n_in} = 5'h17;
    {up_pending_in, pri_term_in} = 2'h0;
    rows = '{'{OFS_CTRL, 32'h0, RESP_OKAY}, '{OFS_PREEMPT, 32'h0, RESP_OKAY},
             '{OFS_STATUS, 32'hc, RESP_OKAY}, '{8'h54, 32'h0, RESP_SLVERR}};
    repeat (8) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    @(posedge ref_clk_in);
    wfor("bridge_gnt", 4, 1'b1, 3);
    chk("gnt_n", 4'hf, sec_gnt_n_out);
    for (int i = 0; i < 4; i++) axr(rows[i].a, rows[i].d, rows[i].r);
    $display("test reset and registers done");
    want <= 4'h1;
    wfor("gnt0", 0, 1'b0, 20);
    repeat (10) @(posedge ref_clk_in);
    want <= 4'h0;
    repeat (30) @(posedge ref_clk_in);
    chk("gnt0_parked", 1'b0, sec_gnt_n_out[0]);
    lazy <= 4'h2;
    want <= 4'h2;
    wfor("gnt1", 1, 1'b0, 20);
    repeat (14) @(posedge ref_clk_in);
    chk("gnt1_held", 1'b0, sec_gnt_n_out[1]);
    wfor("gnt1_dropped", 1, 1'b1, 8);
    want <= 4'h3;
    lazy <= 4'h0;
    wfor("pre_gnt0", 0, 1'b0, 30);
    wfor("pre_gnt1", 1, 1'b0, 30);
    want <= 4'h0;
    $display("test secondary arbitration done");
    axw(OFS_CTRL, 32'h2);
    wfor("park_bridge", 4, 1'b1, 20);
    wfor("sec_ad_oe", 5, 1'b1, 10);
    chk("sec_par_oe", 1'b0, sec_par_oe_out);
    @(posedge ref_clk_in);
    chk("sec_par_oe", 1'b1, sec_par_oe_out);
    axw(OFS_CTRL, 32'h1);
    want <= 4'h4;
    bridge_sec_req_in <= 1'b1;
    sec_ext_gnt_n_in <= 1'b0;
    repeat (12) @(posedge ref_clk_in);
    chk("gnt_off", 4'hf, sec_gnt_n_out);
    chk("ext_req_n", 1'b0, sec_ext_req_n_out);
    chk("ext_bridge_gnt", 1'b1, bridge_sec_gnt_out);
    want <= 4'h0;
    bridge_sec_req_in <= 1'b0;
    sec_ext_gnt_n_in <= 1'b1;
    axw(OFS_CTRL, 32'h0);
    $display("test parking and disable done");
    pri_gnt_n_in <= 1'b0;
    wfor("pri_ad_oe", 6, 1'b1, 8);
    pri_gnt_n_in <= 1'b1;
    wfor("pri_release", 6, 1'b0, 5);
    pri_gnt_n_in <= 1'b0;
    wfor("pri_ad_oe", 6, 1'b1, 8);
    up_pending_in <= 1'b1;
    wfor("pri_start", 7, 1'b1, 6);
    chk("pri_frame_n", 1'b0, pri_frame_n_out);
    chk("pri_frame_oe", 1'b1, pri_frame_oe_out);
    pri_term_in <= 1'b1;
    @(posedge ref_clk_in);
    pri_term_in <= 1'b0;
    @(posedge ref_clk_in);
    chk("pri_req_off", 1'b1, pri_req_n_out);
    @(posedge ref_clk_in);
    chk("pri_req_off", 1'b1, pri_req_n_out);
    @(posedge ref_clk_in);
    chk("pri_req_back", 1'b0, pri_req_n_out);
    $display("test primary done");
    final_report;
  end
endmodule
